// [shared/sshc_regs.svh]
// Purpose: Register offsets, fields, resets and counts of the standby block
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef SSHC_REGS_SVH
`define SSHC_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SSHC_OFS_CTRL     8'h00
`define SSHC_OFS_CMD      8'h04
`define SSHC_OFS_STATUS   8'h08

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SSHC_CTRL_SRC_LSB 0
`define SSHC_CTRL_SEL_LSB 2
`define SSHC_CTRL_STOP_REQ 5
`define SSHC_CMD_STOP     0
`define SSHC_CMD_HALT     1
`define SSHC_ST_MODE_LSB  5
`define SSHC_ST_HS_EN     8
`define SSHC_ST_INT_EN    9

// ------------------------------------------------------------
// Clock source codes and reset values
// ------------------------------------------------------------
`define SSHC_SRC_HS       2'h0
`define SSHC_SRC_INT      2'h1
`define SSHC_SRC_SUB      2'h2
`define SSHC_SEL_RST      3'h4
`define SSHC_SEL_MAX      3'h4

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define SSHC_STAB_BASE    13'h0100
`define SSHC_INT_WAIT     5'h11
`define SSHC_STAT_W       5

`endif

// [shared/sshc_pkg.sv]
// Purpose: Types of the standby block
// Assumes: Nothing
// Notes:   Constants live in sshc_regs.svh
`default_nettype none
package sshc_pkg;

  // ----------------------------------------------------------
  // Standby modes
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    MD_RUN, MD_HALT, MD_STOP, MD_OSCW, MD_STAB, MD_INTW
  } sshc_mode_e;

  // ----------------------------------------------------------
  // Synchroniser state
  // ----------------------------------------------------------
  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic out;
  } sshc_sync_s;

  // ----------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------
  typedef struct packed {
    sshc_mode_e  mode;
    logic [1:0]  cpu_src;
    logic [2:0]  sel;
    logic [2:0]  sel_lat;
    logic        stop_req;
    logic        hs_en;
    logic        int_en;
    logic [4:0]  stat;
    logic [12:0] cnt;
    logic        armed;
    logic [4:0]  ticks;
    logic        tick_prev;
    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic [31:0] rdata;
  } sshc_state_s;

endpackage
`default_nettype wire

// [rtl/sshc_sync3.sv]
// Purpose: Three-flop synchroniser with agreement of the last two stages
// Assumes: Single mclk domain on the output side
// Notes:   Output changes once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none
module sshc_sync3 (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Asynchronous input and its safe copy
  input  wire logic async_in,
  output logic      sync_out
);

  sshc_pkg::sshc_sync_s s_q;
  sshc_pkg::sshc_sync_s s_d;

  // Shift chain; first stage feeds only the second
  always_comb begin
    s_d     = s_q;
    s_d.f1  = async_in;
    s_d.f2  = s_q.f1;
    s_d.f3  = s_q.f2;
    if (s_q.f2 == s_q.f3) begin
      s_d.out = s_q.f3;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.out;

endmodule // sshc_sync3
`default_nettype wire

// [rtl/sshc_ctrl.sv]
// Purpose: STOP/HALT standby controller with stabilization timing
// Assumes: Internal oscillator far slower than mclk; AHB-Lite single slave
// Notes:
// Contract
// - STOP only from high-speed or internal clock; code refuses only the subsystem source, so source code 3 also enters STOP
// - HALT allowed from any clock source
// - STOP on internal clock stops high-speed oscillator
// - STOP never turns internal oscillator off
// - Internal clock: CPU waits 17 oscillator periods
// - Oscillator stop request needs stoppable option
// - Status bits fill from first bit, stay set
// - Counter counts only up to selected interval
// - Wait measured from oscillation start only
// - Pending interrupt turns STOP into HALT wait
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sshc_regs.svh"
module sshc_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // System events and option
  input  wire logic        irq_pending,
  input  wire logic        wake_irq,
  input  wire logic        int_osc_stoppable,
  // Oscillator pins
  input  wire logic        hs_osc_ready_pin,
  input  wire logic        int_osc_clk_pin,
  // Standby outputs
  output logic             cpu_run,
  output logic             hs_osc_en,
  output logic             int_osc_en,
  output logic [4:0]       osc_stab_status_counter
);

  sshc_pkg::sshc_state_s s_q;
  sshc_pkg::sshc_state_s s_d;
  logic                  hs_ok;
  logic                  int_lvl;
  logic                  cmd_stop;
  logic                  cmd_halt;
  logic                  stop_entry;
  logic                  tick;
  logic [12:0]           thr_sel;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  sshc_sync3 u_sync_hs (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (hs_osc_ready_pin),
    .sync_out (hs_ok)
  );

  sshc_sync3 u_sync_int (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (int_osc_clk_pin),
    .sync_out (int_lvl)
  );

  // ----------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------
  // Commands act in the write data phase
  assign cmd_stop = s_q.dph_wr && (s_q.dph_addr == `SSHC_OFS_CMD)
                    && hwdata[`SSHC_CMD_STOP];
  assign cmd_halt = s_q.dph_wr && (s_q.dph_addr == `SSHC_OFS_CMD)
                    && hwdata[`SSHC_CMD_HALT];
  assign stop_entry = (s_q.mode == sshc_pkg::MD_RUN) && cmd_stop
                      && (s_q.cpu_src != `SSHC_SRC_SUB);
  assign tick       = int_lvl && !s_q.tick_prev;
  assign thr_sel    = `SSHC_STAB_BASE << s_q.sel_lat;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.tick_prev = int_lvl;
    // Bus address phase capture
    s_d.dph_wr    = hsel && htrans[1] && hready && hwrite;
    s_d.dph_addr  = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        `SSHC_OFS_CTRL:   s_d.rdata = {26'h0, s_q.stop_req, s_q.sel,
                                       s_q.cpu_src};
        `SSHC_OFS_STATUS: s_d.rdata = {22'h0, s_q.int_en, s_q.hs_en,
                                       s_q.mode, s_q.stat};
        default:          s_d.rdata = 32'h0;
      endcase
    end
    // Control register write
    if (s_q.dph_wr && (s_q.dph_addr == `SSHC_OFS_CTRL)) begin
      s_d.cpu_src = hwdata[`SSHC_CTRL_SRC_LSB +: 2];
      s_d.sel     = (hwdata[`SSHC_CTRL_SEL_LSB +: 3] > `SSHC_SEL_MAX) ?
                    `SSHC_SEL_MAX : hwdata[`SSHC_CTRL_SEL_LSB +: 3];
      s_d.stop_req = hwdata[`SSHC_CTRL_STOP_REQ];
    end
    // Stop request only honoured when the option allows it
    s_d.int_en = !(s_d.stop_req && int_osc_stoppable);
    // Stabilization counter runs from oscillation start only
    if (s_q.armed && hs_ok && s_q.hs_en) begin
      if (s_q.cnt >= thr_sel) begin
        s_d.armed = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + 13'h0001;
      end
    end
    for (int k = 0; k < `SSHC_STAT_W; k++) begin
      if ((s_q.cnt >= (`SSHC_STAB_BASE << k)) && (k <= s_q.sel_lat)) begin
        s_d.stat[k] = 1'b1;
      end
    end
    // Mode sequencing
    unique case (s_q.mode)
      sshc_pkg::MD_RUN: begin
        if (stop_entry) begin
          s_d.stat    = '0;
          s_d.cnt     = '0;
          s_d.armed   = 1'b1;
          s_d.sel_lat = s_q.sel;
          if (irq_pending) begin
            s_d.mode = sshc_pkg::MD_STAB;
          end else begin
            s_d.mode  = sshc_pkg::MD_STOP;
            s_d.hs_en = 1'b0;
          end
        end else if (cmd_halt) begin
          s_d.mode = sshc_pkg::MD_HALT;
        end
      end
      sshc_pkg::MD_HALT: begin
        if (wake_irq) begin
          s_d.mode = sshc_pkg::MD_RUN;
        end
      end
      sshc_pkg::MD_STOP: begin
        if (wake_irq) begin
          s_d.hs_en = 1'b1;
          s_d.ticks = '0;
          s_d.mode  = (s_q.cpu_src == `SSHC_SRC_INT) ?
                      sshc_pkg::MD_INTW : sshc_pkg::MD_OSCW;
        end
      end
      sshc_pkg::MD_OSCW: begin
        if (hs_ok) begin
          s_d.mode = sshc_pkg::MD_STAB;
        end
      end
      sshc_pkg::MD_STAB: begin
        if (!s_q.armed) begin
          s_d.mode = sshc_pkg::MD_RUN;
        end
      end
      sshc_pkg::MD_INTW: begin
        if (s_q.ticks == `SSHC_INT_WAIT) begin
          s_d.mode = sshc_pkg::MD_RUN;
        end else if (tick) begin
          s_d.ticks = s_q.ticks + 5'h01;
        end
      end
      default: s_d.mode = sshc_pkg::MD_RUN;
    endcase
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.mode    <= sshc_pkg::MD_RUN;
      s_q.sel     <= `SSHC_SEL_RST;
      s_q.sel_lat <= `SSHC_SEL_RST;
      s_q.hs_en   <= 1'b1;
      s_q.int_en  <= 1'b1;
      s_q.armed   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign hreadyout  = 1'b1; // Zero-wait slave
  assign hresp      = 1'b0; // Always OKAY
  assign hrdata     = s_q.rdata;
  assign cpu_run    = (s_q.mode == sshc_pkg::MD_RUN);
  assign hs_osc_en  = s_q.hs_en;
  assign int_osc_en = s_q.int_en;
  assign osc_stab_status_counter = s_q.stat;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  property p_stop_src;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.mode == sshc_pkg::MD_RUN && cmd_stop
     && s_q.cpu_src == `SSHC_SRC_SUB)
    |=> (s_q.mode != sshc_pkg::MD_STOP && s_q.mode != sshc_pkg::MD_STAB);
  endproperty
  a_stop_src: assert property (p_stop_src)
    else $error("STOP entered from subsystem clock");

  property p_halt_any;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.mode == sshc_pkg::MD_RUN && cmd_halt && !cmd_stop)
    |=> (s_q.mode == sshc_pkg::MD_HALT);
  endproperty
  a_halt_any: assert property (p_halt_any)
    else $error("HALT command not taken");

  property p_stop_hs_off;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.mode == sshc_pkg::MD_STOP) |-> !hs_osc_en;
  endproperty
  a_stop_hs_off: assert property (p_stop_hs_off)
    else $error("High-speed oscillator running in STOP");

  property p_stop_keeps_int;
    @(posedge mclk) disable iff (!rst_n)
    (stop_entry && int_osc_en && $stable(int_osc_stoppable)) |=> int_osc_en;
  endproperty
  a_stop_keeps_int: assert property (p_stop_keeps_int)
    else $error("STOP entry stopped internal oscillator");

  property p_int_wait;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.mode == sshc_pkg::MD_INTW && s_d.mode == sshc_pkg::MD_RUN)
    |-> (s_q.ticks == 5'h11);
  endproperty
  a_int_wait: assert property (p_int_wait)
    else $error("Resumed before 17 oscillator periods");

  property p_option;
    @(posedge mclk) disable iff (!rst_n)
    !int_osc_stoppable |=> int_osc_en;
  endproperty
  a_option: assert property (p_option)
    else $error("Internal oscillator stopped without option");

  property p_fill;
    @(posedge mclk) disable iff (!rst_n)
    ((s_q.stat & (s_q.stat + 5'h01)) == 5'h00)
    && ($past(stop_entry) || ((s_q.stat & $past(s_q.stat)) == $past(s_q.stat)));
  endproperty
  a_fill: assert property (p_fill)
    else $error("Status bits not filling in order");

  property p_bound;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.stat >> (s_q.sel_lat + 3'h1)) == 5'h00;
  endproperty
  a_bound: assert property (p_bound)
    else $error("Status beyond selected interval");

  property p_no_osc_no_count;
    @(posedge mclk) disable iff (!rst_n)
    (!hs_ok && !stop_entry) |=> (s_q.cnt == $past(s_q.cnt));
  endproperty
  a_no_osc_no_count: assert property (p_no_osc_no_count)
    else $error("Counting before oscillation start");

  property p_pending;
    @(posedge mclk) disable iff (!rst_n)
    (stop_entry && irq_pending) |=> (s_q.mode == sshc_pkg::MD_STAB) && hs_osc_en;
  endproperty
  a_pending: assert property (p_pending)
    else $error("Pending interrupt did not fall back to HALT wait");

  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
    stop_entry |=> (s_q.stat == 5'h00);
  endproperty
  a_clear: assert property (p_clear)
    else $error("Status not cleared at STOP entry");

  // Main scenarios
  c_stop_hs: cover property (@(posedge mclk) disable iff (!rst_n)
    s_q.mode == sshc_pkg::MD_OSCW ##[1:20] s_q.mode == sshc_pkg::MD_STAB);
  c_stop_int: cover property (@(posedge mclk) disable iff (!rst_n)
    s_q.mode == sshc_pkg::MD_INTW ##1 s_q.mode == sshc_pkg::MD_INTW);
  c_halt: cover property (@(posedge mclk) disable iff (!rst_n)
    s_q.mode == sshc_pkg::MD_HALT ##1 s_q.mode == sshc_pkg::MD_RUN);

endmodule // sshc_ctrl
`default_nettype wire

// [bench/sshc_tb.sv]
// Purpose: Self-checking bench of the standby controller
// Assumes: hreadyout feeds hready; oscillator pins modelled here
// Notes:   Waits are measured in mclk cycles against a bench model
`timescale 1ns/100ps
`default_nettype none
`include "sshc_regs.svh"
module testbench;
  // ------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------
  logic        mclk        = 1'b0;
  logic        rst_n       = 1'b0;
  logic        hsel        = 1'b0;
  logic        hwrite      = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic [31:0] hwdata      = 32'h0;
  logic        irq_pending = 1'b0;
  logic        wake_irq    = 1'b0;
  logic        stoppable   = 1'b0;
  logic        hs_ready    = 1'b0;
  logic        int_clk     = 1'b0;
  wire logic   hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cpu_run;
  logic        hs_osc_en;
  logic        int_osc_en;
  logic [4:0]  stat;
  logic [7:0]  seed        = 8'h4d;
  logic [31:0] rd;
  int          fail_count  = 0;
  int          num_checks  = 0;
  int          osc_dly     = 20;
  int          dly_cnt     = 0;
  int          c;
  int          sel_q[$]    = '{0, 1, 2, 3, 4};

  // Clock and free-running internal oscillator, 16 mclk per period
  always #5 mclk = ~mclk;
  always begin
    repeat (8) @(posedge mclk);
    int_clk <= ~int_clk;
  end

  // High-speed oscillator starts some cycles after its enable
  always @(posedge mclk) begin
    if (hs_osc_en !== 1'b1) begin
      dly_cnt  <= 0;
      hs_ready <= 1'b0;
    end else if (dly_cnt < osc_dly) begin
      dly_cnt <= dly_cnt + 1;
    end else begin
      hs_ready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Device under test
  // ------------------------------------------------------------
  sshc_ctrl u_dut (
    .mclk                    (mclk),
    .rst_n                   (rst_n),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (3'h2),
    .hwdata                  (hwdata),
    .hready                  (hready),
    .hreadyout               (hready),
    .hresp                   (hresp),
    .hrdata                  (hrdata),
    .irq_pending             (irq_pending),
    .wake_irq                (wake_irq),
    .int_osc_stoppable       (stoppable),
    .hs_osc_ready_pin        (hs_ready),
    .int_osc_clk_pin         (int_clk),
    .cpu_run                 (cpu_run),
    .hs_osc_en               (hs_osc_en),
    .int_osc_en              (int_osc_en),
    .osc_stab_status_counter (stat)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Status bits expected once select k has run out
  function automatic logic [31:0] exp_stat(input int k);
    return (32'h1 << (k + 1)) - 32'h1;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Range checks go through the one compare task; lower bound shown on miss
  task automatic in_range(input string name, input int v, lo, hi);
    check(name, 32'(v), (v < lo || v > hi) ? 32'(lo) : 32'(v));
  endtask

  // One AHB-Lite single transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
    check("hresp", 32'(hresp), 32'h0);
    #1;
  endtask

  // Cycles until the CPU runs again
  task automatic wait_run(output int n);
    n = 0;
    while (cpu_run !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // STOP with source src and select k, then wake; n is the wait
  task automatic stop_run(input logic [1:0] src, input int k,
                          output int n);
    ahb(1'b1, `SSHC_OFS_CTRL, (32'(k) << 2) | 32'(src));
    // No other activity runs while the stop command goes out
    ahb(1'b1, `SSHC_OFS_CMD, 32'h1);
    ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
    check("stop status", rd, 32'h240);
    seed = lfsr(seed);
    osc_dly = 16 + int'(seed[5:0]);
    repeat (8 + int'(seed[4:0])) @(posedge mclk);
    wake_irq <= 1'b1;
    n = 0;
    while (src == `SSHC_SRC_HS && hs_ready !== 1'b1 && n < 500) begin
      @(posedge mclk);
      #1;
      n++;
    end
    wait_run(n);
    @(posedge mclk) wake_irq <= 1'b0;
  endtask

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    ahb(1'b0, `SSHC_OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h10);
    ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
    check("status reset", rd, 32'h300);
    repeat (4200) @(posedge mclk);
    ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
    check("status filled", rd, 32'h31f);
    ahb(1'b1, `SSHC_OFS_CTRL, 32'h1c);
    ahb(1'b0, `SSHC_OFS_CTRL, 32'h0);
    check("select clamp", rd, 32'h10);
    ahb(1'b1, `SSHC_OFS_STATUS, 32'h0);
    ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
    check("status ro", rd, 32'h31f);
    ahb(1'b0, 8'h0c, 32'h0);
    check("unmapped", rd, 32'h0);
    ahb(1'b0, `SSHC_OFS_CMD, 32'h0);
    check("cmd read", rd, 32'h0);
    $display("Test registers done");
    for (c = 0; c < 2; c++) begin
      @(posedge mclk) stoppable <= c[0];
      ahb(1'b1, `SSHC_OFS_CTRL, 32'h30);
      repeat (2) @(posedge mclk);
      #1;
      check("int_osc_en", 32'(int_osc_en), 32'(c == 0));
    end
    ahb(1'b1, `SSHC_OFS_CTRL, 32'h12);
    ahb(1'b1, `SSHC_OFS_CMD, 32'h1);
    ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
    check("stop on sub", rd, 32'h31f);
    $display("Test option and sub stop done");
    foreach (sel_q[i]) begin
      if (i < 3) begin
        ahb(1'b1, `SSHC_OFS_CTRL, 32'h10 | 32'(i));
        ahb(1'b1, `SSHC_OFS_CMD, 32'h2);
        check("halt cpu_run", 32'(cpu_run), 32'h0);
        check("halt hs_osc_en", 32'(hs_osc_en), 32'h1);
        @(posedge mclk) wake_irq <= 1'b1;
        wait_run(c);
        @(posedge mclk) wake_irq <= 1'b0;
        in_range("halt wake", c, 0, 3);
      end
    end
    $display("Test halt done");
    foreach (sel_q[i]) begin
      stop_run(`SSHC_SRC_HS, sel_q[i], c);
      in_range("stab wait", c, 256 << sel_q[i], (256 << sel_q[i]) + 10);
      repeat (300) @(posedge mclk);
      ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
      check("status sel", rd, 32'h300 | exp_stat(sel_q[i]));
      check("status pins", 32'(stat), exp_stat(sel_q[i]));
    end
    $display("Test stop high-speed done");
    // Longest select covers the internal-clock wait
    stop_run(`SSHC_SRC_INT, 4, c);
    in_range("int wait", c, 16 * 16, 18 * 16 + 8);
    $display("Test stop internal done");
    ahb(1'b1, `SSHC_OFS_CTRL, 32'h0);
    @(posedge mclk) irq_pending <= 1'b1;
    ahb(1'b1, `SSHC_OFS_CMD, 32'h1);
    ahb(1'b0, `SSHC_OFS_STATUS, 32'h0);
    check("fallback status", rd, 32'h380);
    wait_run(c);
    in_range("fallback wait", c, 240, 264);
    @(posedge mclk) irq_pending <= 1'b0;
    $display("Test pending interrupt done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
